// ==== cpp_battery_model.sv ====
// Battery and power stage model driving the battery comparators
`timescale 1ns/1ps
module cpp_battery_model
(
	input  wire logic       clk,
	input  wire logic       load,
	input  wire logic [7:0] load_level,
	input  wire logic       converter_en,
	input  wire logic       battery_switch_gate,
	input  wire logic       linear_safe_en,
	input  wire logic       linear_weak_en,
	output logic            bat_above_safe,
	output logic            bat_above_pre,
	output logic            bat_above_weak_threshold,
	output logic            bat_above_recharge
);
	// ==========================================
	// Cell voltage rises slowly, up to 8'h6E and then holds, while any source feeds it
	logic [7:0] level_reg = 8'h00;
	logic [3:0] div_reg   = 4'h0;
	wire        feeding   = linear_safe_en || linear_weak_en || (converter_en && !battery_switch_gate);

	always @(posedge clk)
	begin
		div_reg <= div_reg + 4'h1;
		if (load)
			level_reg <= load_level;
		else if (feeding && div_reg == 4'hF && level_reg < 8'h6E)
			level_reg <= level_reg + 8'h01;
	end

	assign bat_above_safe           = level_reg > 8'h14;
	assign bat_above_pre            = level_reg > 8'h28;
	assign bat_above_weak_threshold = level_reg > 8'h3C;
	assign bat_above_recharge       = level_reg > 8'h64;
endmodule

// ==== cpp_checker.sv ====
// Concurrent checks on the ports of the charger control block
`timescale 1ns/1ps
module cpp_checker
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [3:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_write,
	input wire logic        input_detected,
	input wire logic        input_overvoltage,
	input wire logic        bat_above_weak_threshold,
	input wire logic        sense_below_recharge,
	input wire logic        temp_warn,
	input wire logic        temp_step_one,
	input wire logic        temp_step_two,
	input wire logic        temp_shutdown,
	input wire logic        battery_switch_gate,
	input wire logic        converter_en,
	input wire logic        linear_safe_en,
	input wire logic        linear_weak_en,
	input wire logic        limit_active,
	input wire logic [3:0]  charge_current_out,
	input wire logic        thermal_irq
);
	// ==========================================
	// Shadow of control bits
	logic derate_reg;
	logic ppath_reg;
	wire  temp_any = temp_warn || temp_step_one || temp_step_two;
	wire  ctrl_wr  = reg_write && (reg_addr == cpp_pkg::CTRL_ADDR);

	always_ff @(posedge clk)
	begin
		if (!rst_n || (ctrl_wr && reg_wdata[cpp_pkg::REG_RST_BIT]))
		begin
			derate_reg <= 1'b0;
			ppath_reg  <= 1'b0;
		end
		else if (ctrl_wr)
		begin
			derate_reg <= reg_wdata[cpp_pkg::DERATE_BIT];
			ppath_reg  <= reg_wdata[cpp_pkg::PPATH_BIT];
		end
	end

	// ==========================================
	// Assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	AST_GATE_OPEN_CONV: assert property ($rose(battery_switch_gate) |-> converter_en)
		else $error("Switch opened with converter off");
	AST_LINEAR_PATH: assert property (
		(linear_safe_en || linear_weak_en) |-> converter_en && battery_switch_gate)
		else $error("Linear source on with switch closed or converter off");
	AST_LINEAR_ONE: assert property (!(linear_safe_en && linear_weak_en))
		else $error("Both linear sources on");
	AST_IRQ_PULSE: assert property (thermal_irq |=> !thermal_irq)
		else $error("Thermal request longer than one cycle");
	AST_IRQ_CAUSE: assert property (thermal_irq |-> $past(temp_any, 2) ||
		$past(temp_any, 3) || $past(temp_any, 4) || $past(temp_any, 5))
		else $error("Thermal request without temperature event");
	AST_LIMIT_RANGE: assert property (
		(!input_detected || input_overvoltage)[*5] |-> !limit_active)
		else $error("Limiting outside input window");
	AST_SD_HALT: assert property (
		temp_shutdown[*8] |-> !linear_safe_en && !linear_weak_en)
		else $error("Charging during thermal shutdown");
	AST_DERATE_LOW: assert property (
		(derate_reg && temp_step_two)[*8] |-> charge_current_out == cpp_pkg::CHARGE_CURRENT_FIELD_LOWEST)
		else $error("Current not at lowest step at level two");
	AST_GATE_ABOVE_WEAK: assert property (
		(!ppath_reg && bat_above_weak_threshold)[*8] |-> !battery_switch_gate)
		else $error("Switch open above weak threshold");
	AST_RECLOSE: assert property (
		(bat_above_weak_threshold && sense_below_recharge)[*5] |-> !battery_switch_gate)
		else $error("Switch not reclosed on system sag");

	COV_WEAK: cover property (linear_weak_en);
	COV_OPEN: cover property ($rose(battery_switch_gate));
	COV_IRQ: cover property (thermal_irq);
endmodule

// ==== cpp_pkg.sv ====
// Package with constants and state type of the charger power path control
package cpp_pkg;

	// ==========================================
	// Register map (index equals word address)
	localparam logic [3:0] CTRL_ADDR    = 4'h0;
	localparam logic [3:0] LIMIT_ADDR   = 4'h1;
	localparam logic [3:0] CURRENT_ADDR = 4'h2;
	localparam logic [3:0] STATUS_ADDR  = 4'h3;
	localparam logic [3:0] THERM_ADDR   = 4'h4;

	// ==========================================
	// Control register bit positions
	localparam int CHARGE_ENABLE_BIT_BIT   = 0;
	localparam int REG_RST_BIT  = 1;
	localparam int TCLR_BIT     = 2;
	localparam int PPATH_BIT    = 3;
	localparam int WD_DIS_BIT   = 4;
	localparam int CT_DIS_BIT   = 5;
	localparam int LIM_EN_BIT   = 6;
	localparam int AUTO_EN_BIT  = 7;
	localparam int DERATE_BIT   = 8;
	localparam int LIM_OVR_BIT  = 9;
	localparam logic [9:0] CTRL_RESET = 10'h041;

	// ==========================================
	// Limit codes and reset values
	localparam logic [1:0] LIM_100 = 2'h0;
	localparam logic [1:0] LIM_500 = 2'h2;
	localparam logic [1:0] LIM_900 = 2'h3;
	localparam logic [1:0] LIM_RESET = 2'h0;
	localparam logic [3:0] CHARGE_CURRENT_FIELD_RESET  = 4'hF;
	localparam logic [3:0] WEAK_CURRENT_FIELD_RESET = 4'h3;
	localparam logic [3:0] DERATE_STEPS = 4'h2;
	localparam logic [3:0] CHARGE_CURRENT_FIELD_LOWEST  = 4'h0;

	// ==========================================
	// Timing
	localparam longint CLK_HZ        = 125000000;
	localparam longint TICK_US       = 1000;
	localparam int     TICK_CYCLES   = int'(CLK_HZ * TICK_US / 1000000);
	localparam int     AUTO_STEP_US  = 10;
	localparam int     AUTO_CYCLES   = int'(CLK_HZ * AUTO_STEP_US / 1000000);
	localparam logic [19:0] WD_MS    = 20'd32000;
	localparam logic [24:0] CHG_MS   = 25'd18000000;
	localparam logic [23:0] USB_MS   = 24'd2700000;
	localparam logic [19:0] WU_MS    = 20'd900000;
	localparam logic [1:0]  POWER_FAIL_TOGGLES = 2'h3;

	// ==========================================
	// Charger states, one-hot
	typedef enum logic [11:0] {
		ST_OFF         = 12'h001,
		ST_CONFIG      = 12'h002,
		ST_WAIT        = 12'h004,
		ST_WEAK_WAIT   = 12'h008,
		ST_WEAK_SAFE   = 12'h010,
		ST_WEAK_CHARGE = 12'h020,
		ST_SAFE        = 12'h040,
		ST_PRE         = 12'h080,
		ST_FULL        = 12'h100,
		ST_EOC         = 12'h200,
		ST_FAULT       = 12'h400
	} cpp_state_t;

endpackage

// ==== cpp_top.sv ====
// Control logic of the charger: weak battery states, power path, timers, limits
`timescale 1ns/1ps

module cpp_top
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [15:0] reg_rdata,
	input  wire logic        system_power_monitor_pin,
	input  wire logic        current_select_pin_a,
	input  wire logic        current_select_pin_b,
	input  wire logic        input_detected,
	input  wire logic        input_overvoltage,
	input  wire logic        bat_above_safe,
	input  wire logic        bat_above_pre,
	input  wire logic        bat_above_weak_threshold,
	input  wire logic        bat_above_recharge,
	input  wire logic        sense_below_recharge,
	input  wire logic        charge_current_low,
	input  wire logic        input_sag,
	input  wire logic        gate_probe_high,
	input  wire logic        temp_warn,
	input  wire logic        temp_step_one,
	input  wire logic        temp_step_two,
	input  wire logic        temp_shutdown,
	output logic             battery_switch_gate,
	output logic             gate_probe_en,
	output logic             converter_en,
	output logic             linear_safe_en,
	output logic             linear_weak_en,
	output logic             limit_active,
	output logic [1:0]       input_current_ceiling,
	output logic [3:0]       charge_current_out,
	output logic             thermal_irq
);

	// ==========================================
	// Synchronisers for pins and comparators
	localparam int NS = 17;
	logic [NS-1:0] raw_in;
	logic [NS-1:0] sync1_reg;
	logic [NS-1:0] sync2_reg;
	assign raw_in = {system_power_monitor_pin, current_select_pin_a, current_select_pin_b,
		input_detected, input_overvoltage, bat_above_safe, bat_above_pre,
		bat_above_weak_threshold, bat_above_recharge, sense_below_recharge,
		charge_current_low, input_sag, gate_probe_high, temp_warn, temp_step_one,
		temp_step_two, temp_shutdown};

	genvar gi;
	generate
		for (gi = 0; gi < NS; gi++)
		begin : g_sync
			always_ff @(posedge clk)
			begin
				if (!rst_n)
				begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
				end
				else
				begin
					sync1_reg[gi] <= raw_in[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	wire s_spm      = sync2_reg[16];
	wire s_pin_a    = sync2_reg[15];
	wire s_pin_b    = sync2_reg[14];
	wire s_in_det   = sync2_reg[13];
	wire s_in_ov    = sync2_reg[12];
	wire s_safe     = sync2_reg[11];
	wire s_pre      = sync2_reg[10];
	wire s_weak     = sync2_reg[9];
	wire s_rechg    = sync2_reg[8];
	wire s_sense_lo = sync2_reg[7];
	wire s_eoc_i    = sync2_reg[6];
	wire s_sag      = sync2_reg[5];
	wire s_probe    = sync2_reg[4];
	wire s_warn     = sync2_reg[3];
	wire s_m1       = sync2_reg[2];
	wire s_m2       = sync2_reg[1];
	wire s_sd       = sync2_reg[0];

	// ==========================================
	// Registers
	logic [9:0]  ctrl_reg;
	logic [1:0]  lim_reg;
	logic [3:0]  charge_current_field_reg;
	logic [3:0]  weak_current_field_reg;
	logic        watchdog_timeout_flag_reg;
	logic        switch_present_reg;
	cpp_pkg::cpp_state_t state_reg;
	cpp_pkg::cpp_state_t state_next;

	wire wr_ctrl  = reg_write && (reg_addr == cpp_pkg::CTRL_ADDR);
	wire wr_lim   = reg_write && (reg_addr == cpp_pkg::LIMIT_ADDR);
	wire wr_cur   = reg_write && (reg_addr == cpp_pkg::CURRENT_ADDR);
	wire reg_rst  = wr_ctrl && reg_wdata[cpp_pkg::REG_RST_BIT];
	wire tclr     = wr_ctrl && reg_wdata[cpp_pkg::TCLR_BIT];
	wire unplug   = !s_in_det;
	wire charge_enable_bit   = ctrl_reg[cpp_pkg::CHARGE_ENABLE_BIT_BIT];

	always_ff @(posedge clk)
	begin
		if (!rst_n || reg_rst)
		begin
			ctrl_reg  <= cpp_pkg::CTRL_RESET;
			lim_reg   <= cpp_pkg::LIM_RESET;
			charge_current_field_reg  <= cpp_pkg::CHARGE_CURRENT_FIELD_RESET;
			weak_current_field_reg <= cpp_pkg::WEAK_CURRENT_FIELD_RESET;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_reg <= reg_wdata[9:0] & ~10'h006;
			if (wr_lim)
				lim_reg <= reg_wdata[1:0];
			if (wr_cur)
			begin
				charge_current_field_reg  <= reg_wdata[3:0];
				weak_current_field_reg <= reg_wdata[7:4];
			end
		end
	end

	// ==========================================
	// Input limit selection
	wire auto_mode = (!s_pin_a && s_pin_b) || ctrl_reg[cpp_pkg::AUTO_EN_BIT];
	wire [1:0] pin_lim = {s_pin_a, s_pin_b};
	wire [1:0] sel_lim = ctrl_reg[cpp_pkg::LIM_OVR_BIT] ? lim_reg : pin_lim;
	wire lim_en    = ctrl_reg[cpp_pkg::LIM_EN_BIT];
	wire lowest    = lim_en && (sel_lim == cpp_pkg::LIM_100) && !auto_mode;
	wire above_100 = !lowest;

	// ==========================================
	// Shared timebase and timers
	logic [16:0] tick_cnt_reg;
	wire tick = (tick_cnt_reg == 17'(cpp_pkg::TICK_CYCLES - 1));
	always_ff @(posedge clk)
	begin
		if (!rst_n || tick)
			tick_cnt_reg <= 17'h00000;
		else
			tick_cnt_reg <= tick_cnt_reg + 17'h00001;
	end

	wire off_st   = (state_reg == cpp_pkg::ST_OFF);
	wire active   = state_reg inside {cpp_pkg::ST_WEAK_SAFE, cpp_pkg::ST_WEAK_CHARGE,
		cpp_pkg::ST_SAFE, cpp_pkg::ST_PRE, cpp_pkg::ST_FULL};
	wire fault_st = (state_reg == cpp_pkg::ST_FAULT);
	wire weak_run = state_reg inside {cpp_pkg::ST_WEAK_WAIT, cpp_pkg::ST_WEAK_SAFE};

	logic [19:0] wd_reg;
	logic [24:0] ct_reg;
	logic [23:0] usb_reg;
	logic [19:0] wu_reg;
	wire wd_exp  = !ctrl_reg[cpp_pkg::WD_DIS_BIT] && (wd_reg >= cpp_pkg::WD_MS);
	wire ct_exp  = !ctrl_reg[cpp_pkg::CT_DIS_BIT] && (ct_reg >= cpp_pkg::CHG_MS);
	wire usb_exp = usb_reg >= cpp_pkg::USB_MS;
	wire wu_exp  = wu_reg >= cpp_pkg::WU_MS;

	always_ff @(posedge clk)
	begin
		if (!rst_n || off_st)
		begin
			wd_reg  <= 20'h00000;
			ct_reg  <= 25'h0000000;
			usb_reg <= 24'h000000;
			wu_reg  <= 20'h00000;
		end
		else
		begin
			if (reg_write || ctrl_reg[cpp_pkg::WD_DIS_BIT])
				wd_reg <= 20'h00000;
			else if (tick && (active || fault_st) && !wd_exp)
				wd_reg <= wd_reg + 20'h00001;
			if (tclr)
				ct_reg <= 25'h0000000;
			else if (tick && active && !ct_exp)
				ct_reg <= ct_reg + 25'h0000001;
			if (tclr)
				usb_reg <= 24'h000000;
			else if (tick && active && lowest && !usb_exp)
				usb_reg <= usb_reg + 24'h000001;
			if (above_100 || !weak_run)
				wu_reg <= 20'h00000;
			else if (tick && !wu_exp)
				wu_reg <= wu_reg + 20'h00001;
		end
	end

	// ==========================================
	// Monitor pin toggle counter
	logic       spm_d_reg;
	logic [1:0] tog_reg;
	wire weak_chg = state_reg inside {cpp_pkg::ST_WEAK_WAIT, cpp_pkg::ST_WEAK_SAFE,
		cpp_pkg::ST_WEAK_CHARGE};
	wire spm_tog  = s_spm != spm_d_reg;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			spm_d_reg <= 1'b0;
			tog_reg   <= 2'h0;
		end
		else
		begin
			spm_d_reg <= s_spm;
			if (!weak_chg || unplug)
				tog_reg <= 2'h0;
			else if (spm_tog && tog_reg != cpp_pkg::POWER_FAIL_TOGGLES)
				tog_reg <= tog_reg + 2'h1;
		end
	end
	wire power_fail = weak_chg && spm_tog && (tog_reg == 2'h2);

	// ==========================================
	// State machine
	wire timeout = wd_exp || ct_exp || usb_exp ||
		(wu_exp && state_reg != cpp_pkg::ST_WEAK_SAFE);
	wire ppath   = ctrl_reg[cpp_pkg::PPATH_BIT] && switch_present_reg;

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			cpp_pkg::ST_OFF:         state_next = cpp_pkg::ST_CONFIG;
			cpp_pkg::ST_CONFIG:      state_next = cpp_pkg::ST_WAIT;
			cpp_pkg::ST_WAIT:
				if (switch_present_reg && !s_weak && !s_spm)
					state_next = cpp_pkg::ST_WEAK_WAIT;
				else
					state_next = cpp_pkg::ST_SAFE;
			cpp_pkg::ST_WEAK_WAIT:   state_next = cpp_pkg::ST_WEAK_SAFE;
			cpp_pkg::ST_WEAK_SAFE:
				if (wu_exp)
					state_next = cpp_pkg::ST_SAFE;
				else if (s_safe)
					state_next = cpp_pkg::ST_WEAK_CHARGE;
			cpp_pkg::ST_WEAK_CHARGE:
				if (s_weak)
					state_next = cpp_pkg::ST_FULL;
			cpp_pkg::ST_SAFE:        if (s_safe) state_next = cpp_pkg::ST_PRE;
			cpp_pkg::ST_PRE:         if (s_pre) state_next = cpp_pkg::ST_FULL;
			cpp_pkg::ST_FULL:        if (s_rechg && s_eoc_i) state_next = cpp_pkg::ST_EOC;
			cpp_pkg::ST_EOC:         if (!s_rechg) state_next = cpp_pkg::ST_FULL;
			cpp_pkg::ST_FAULT:
				if (wd_exp)
					state_next = cpp_pkg::ST_OFF;
				else if (charge_enable_bit && !s_sd)
					state_next = cpp_pkg::ST_WAIT;
			default:                 state_next = cpp_pkg::ST_OFF;
		endcase
		if (power_fail)
			state_next = cpp_pkg::ST_SAFE;
		if (state_reg != cpp_pkg::ST_OFF && state_reg != cpp_pkg::ST_FAULT &&
			(!charge_enable_bit || timeout || s_sd))
			state_next = cpp_pkg::ST_FAULT;
		if (unplug)
			state_next = cpp_pkg::ST_OFF;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			state_reg <= cpp_pkg::ST_OFF;
		else
			state_reg <= state_next;
	end

	// ==========================================
	// Switch detection and watchdog flag
	always_ff @(posedge clk)
	begin
		if (!rst_n || unplug || reg_rst)
			switch_present_reg <= 1'b0;
		else if (state_reg == cpp_pkg::ST_CONFIG)
			switch_present_reg <= s_probe;
		if (!rst_n)
			watchdog_timeout_flag_reg <= 1'b0;
		else if (wd_exp && (active || fault_st))
			watchdog_timeout_flag_reg <= 1'b1;
		else if (reg_read && reg_addr == cpp_pkg::STATUS_ADDR)
			watchdog_timeout_flag_reg <= 1'b0;
	end

	// ==========================================
	// Switch path: open in weak states, and in end of charge with power path
	logic sw_open_reg;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			sw_open_reg <= 1'b0;
		else if (!switch_present_reg)
			sw_open_reg <= 1'b0;
		else if (weak_chg)
			sw_open_reg <= 1'b1;
		else if (state_reg == cpp_pkg::ST_EOC && ppath && !s_sense_lo)
			sw_open_reg <= 1'b1;
		else
			sw_open_reg <= 1'b0;
	end

	// ==========================================
	// Automatic charge current and thermal derating
	logic [3:0]  auto_reg;
	logic        held_reg;
	logic [10:0] astep_reg;
	logic        warn_d_reg;
	logic        m1_d_reg;
	logic        m2_d_reg;
	wire astep = astep_reg == 11'(cpp_pkg::AUTO_CYCLES - 1);
	always_ff @(posedge clk)
	begin
		if (!rst_n || !auto_mode || !active)
		begin
			auto_reg  <= 4'h0;
			held_reg  <= 1'b0;
			astep_reg <= 11'h000;
		end
		else
		begin
			astep_reg <= astep ? 11'h000 : astep_reg + 11'h001;
			if (s_sag && !held_reg)
			begin
				held_reg <= 1'b1;
				if (auto_reg != 4'h0)
					auto_reg <= auto_reg - 4'h1;
			end
			else if (astep && !held_reg && auto_reg < charge_current_field_reg)
				auto_reg <= auto_reg + 4'h1;
		end
	end

	wire [3:0] base_i = (state_reg == cpp_pkg::ST_WEAK_CHARGE) ? weak_current_field_reg
		: auto_mode ? auto_reg : charge_current_field_reg;
	wire derate = ctrl_reg[cpp_pkg::DERATE_BIT] && s_warn;
	wire [3:0] m1_i = (base_i > cpp_pkg::DERATE_STEPS) ? base_i - cpp_pkg::DERATE_STEPS
		: cpp_pkg::CHARGE_CURRENT_FIELD_LOWEST;
	wire [3:0] eff_i = !derate ? base_i : s_m2 ? cpp_pkg::CHARGE_CURRENT_FIELD_LOWEST : s_m1 ? m1_i : base_i;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			warn_d_reg  <= 1'b0;
			m1_d_reg    <= 1'b0;
			m2_d_reg    <= 1'b0;
			thermal_irq <= 1'b0;
			charge_current_out <= 4'h0;
			input_current_ceiling <= cpp_pkg::LIM_100;
		end
		else
		begin
			warn_d_reg  <= s_warn;
			m1_d_reg    <= s_m1;
			m2_d_reg    <= s_m2;
			thermal_irq <= (s_warn && !warn_d_reg) ||
				(ctrl_reg[cpp_pkg::DERATE_BIT] && ((s_m1 && !m1_d_reg) || (s_m2 && !m2_d_reg)));
			charge_current_out <= eff_i;
			input_current_ceiling <= auto_mode ? cpp_pkg::LIM_900 : sel_lim;
		end
	end

	// ==========================================
	// Outputs
	assign battery_switch_gate = sw_open_reg;
	assign gate_probe_en  = (state_reg == cpp_pkg::ST_CONFIG);
	assign converter_en   = active || state_reg inside {cpp_pkg::ST_WEAK_WAIT, cpp_pkg::ST_EOC};
	assign linear_safe_en = (state_reg == cpp_pkg::ST_WEAK_SAFE);
	assign linear_weak_en = (state_reg == cpp_pkg::ST_WEAK_CHARGE);
	assign limit_active   = lim_en && s_in_det && !s_in_ov;

	// ==========================================
	// Read data
	logic [15:0] rd_mux;
	always_comb
	begin
		case (reg_addr)
			cpp_pkg::CTRL_ADDR:    rd_mux = {6'h00, ctrl_reg};
			cpp_pkg::LIMIT_ADDR:   rd_mux = {14'h0000, lim_reg};
			cpp_pkg::CURRENT_ADDR: rd_mux = {8'h00, weak_current_field_reg, charge_current_field_reg};
			cpp_pkg::STATUS_ADDR:  rd_mux = {2'h0, watchdog_timeout_flag_reg, switch_present_reg, state_reg[11:0]};
			cpp_pkg::THERM_ADDR:   rd_mux = {12'h000, s_sd, s_m2, s_m1, s_warn};
			default:               rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			reg_rdata <= 16'h0000;
		else if (reg_read)
			reg_rdata <= rd_mux;
		else
			reg_rdata <= 16'h0000;
	end

endmodule

// ==== tb_top.sv ====
// Self-checking testbench of the charger control block
`timescale 1ns/1ps
module tb_top;
	// ==========================================
	// Signals
	logic        clk = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd_data;
	logic        system_power_monitor_pin = 1'b0, input_detected = 1'b0;
	logic        current_select_pin_a = 1'b0, current_select_pin_b = 1'b0;
	logic        input_overvoltage = 1'b0, sense_below_recharge = 1'b0, input_sag = 1'b0;
	logic        charge_current_low = 1'b0, gate_probe_high = 1'b1, load = 1'b1;
	logic        temp_warn = 1'b0, temp_step_one = 1'b0, temp_step_two = 1'b0;
	logic        temp_shutdown = 1'b0;
	logic [7:0]  load_level = 8'h00;
	logic        bat_above_safe, bat_above_pre, bat_above_weak_threshold, bat_above_recharge;
	logic        battery_switch_gate, gate_probe_en, converter_en, linear_safe_en;
	logic        linear_weak_en, limit_active, thermal_irq;
	logic [1:0]  input_current_ceiling;
	logic [3:0]  charge_current_out;
	int          miscompares = 0, checked = 0, cycles = 0, irq_count = 0;

	always #4 clk = ~clk;

	cpp_top uut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
		.system_power_monitor_pin, .current_select_pin_a, .current_select_pin_b,
		.input_detected, .input_overvoltage, .bat_above_safe, .bat_above_pre,
		.bat_above_weak_threshold, .bat_above_recharge, .sense_below_recharge,
		.charge_current_low, .input_sag, .gate_probe_high, .temp_warn, .temp_step_one,
		.temp_step_two, .temp_shutdown, .battery_switch_gate, .gate_probe_en, .converter_en,
		.linear_safe_en, .linear_weak_en, .limit_active, .input_current_ceiling,
		.charge_current_out, .thermal_irq);

	cpp_battery_model plant (.clk, .load, .load_level, .converter_en, .battery_switch_gate,
		.linear_safe_en, .linear_weak_en, .bat_above_safe, .bat_above_pre,
		.bat_above_weak_threshold, .bat_above_recharge);

	// ==========================================
	// Tasks
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		@(posedge clk);
		rd_data = reg_rdata;
	endtask

	task automatic wait_state(input logic [11:0] st, input int n);
		for (int i = 0; i < n; i++)
		begin
			rd(cpp_pkg::STATUS_ADDR);
			if (rd_data[11:0] === st)
				break;
		end
		check("state", {4'h0, st}, {4'h0, rd_data[11:0]});
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
	endtask

	// ==========================================
	// Timeout and request counting
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (thermal_irq === 1'b1)
			irq_count <= irq_count + 1;
		if (cycles == 60000)
		begin
			miscompares++;
			wrap_up();
		end
	end

	// ==========================================
	// Tests
	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		load  <= 1'b0;
		rd(cpp_pkg::CTRL_ADDR);
		check("ctrl", {6'h00, cpp_pkg::CTRL_RESET}, rd_data);
		rd(cpp_pkg::CURRENT_ADDR);
		check("current", {8'h00, cpp_pkg::WEAK_CURRENT_FIELD_RESET, cpp_pkg::CHARGE_CURRENT_FIELD_RESET}, rd_data);
		rd(cpp_pkg::STATUS_ADDR);
		check("status", 16'h0001, rd_data);
		wr(4'h9, 16'hFFFF);
		rd(4'h9);
		check("unmapped", 16'h0000, rd_data);
		$display("Test reset values done");

		input_detected <= 1'b1;
		for (int i = 0; i < 20 && gate_probe_en !== 1'b1; i++)
			@(posedge clk);
		check("probe", 16'h1, {15'h0, gate_probe_en});
		wait_state(cpp_pkg::ST_WEAK_SAFE, 40);
		check("present", 16'h1, {15'h0, rd_data[12]});
		check("safe src", 16'h1, {15'h0, linear_safe_en});
		check("gate open", 16'h1, {15'h0, battery_switch_gate});
		wait_state(cpp_pkg::ST_WEAK_CHARGE, 400);
		check("weak src", 16'h1, {15'h0, linear_weak_en});
		check("weak current", {12'h0, cpp_pkg::WEAK_CURRENT_FIELD_RESET}, {12'h0, charge_current_out});
		wait_state(cpp_pkg::ST_FULL, 400);
		settle(4);
		check("gate closed", 16'h0, {15'h0, battery_switch_gate});
		$display("Test weak battery path done");

		wr(cpp_pkg::CTRL_ADDR, 16'h0141);
		temp_warn <= 1'b1;
		settle(8);
		rd(cpp_pkg::THERM_ADDR);
		check("warn sense", 16'h1, rd_data & 16'h1);
		temp_step_one <= 1'b1;
		settle(8);
		check("step one", {12'h0, cpp_pkg::CHARGE_CURRENT_FIELD_RESET - cpp_pkg::DERATE_STEPS}, {12'h0, charge_current_out});
		temp_step_two <= 1'b1;
		settle(8);
		check("step two", {12'h0, cpp_pkg::CHARGE_CURRENT_FIELD_LOWEST}, {12'h0, charge_current_out});
		temp_warn     <= 1'b0;
		temp_step_one <= 1'b0;
		temp_step_two <= 1'b0;
		settle(8);
		check("restore", {12'h0, cpp_pkg::CHARGE_CURRENT_FIELD_RESET}, {12'h0, charge_current_out});
		check("requests", 16'h3, irq_count[15:0]);
		$display("Test thermal derating done");

		wr(cpp_pkg::CTRL_ADDR, 16'h0049);
		charge_current_low <= 1'b1;
		wait_state(cpp_pkg::ST_EOC, 400);
		settle(4);
		check("pp open", 16'h1, {15'h0, battery_switch_gate});
		sense_below_recharge <= 1'b1;
		settle(5);
		check("pp closed", 16'h0, {15'h0, battery_switch_gate});
		sense_below_recharge <= 1'b0;
		wr(cpp_pkg::CTRL_ADDR, 16'h0040);
		wait_state(cpp_pkg::ST_FAULT, 20);
		charge_current_low <= 1'b0;
		wr(cpp_pkg::CTRL_ADDR, 16'h0041);
		wait_state(cpp_pkg::ST_FULL, 40);
		temp_shutdown <= 1'b1;
		wait_state(cpp_pkg::ST_FAULT, 20);
		temp_shutdown <= 1'b0;
		$display("Test power path and halts done");

		for (int i = 0; i < 4; i++)
		begin
			current_select_pin_a <= i[1];
			current_select_pin_b <= i[0];
			settle(8);
			check("ceiling", (i == 1) ? {14'h0, cpp_pkg::LIM_900} : i[15:0],
				{14'h0, input_current_ceiling});
		end
		current_select_pin_a <= 1'b0;
		current_select_pin_b <= 1'b1;
		settle(3000);
		check("auto rise", 16'h2, {12'h0, charge_current_out});
		input_sag <= 1'b1;
		settle(8);
		check("auto back", 16'h1, {12'h0, charge_current_out});
		settle(1300);
		check("auto hold", 16'h1, {12'h0, charge_current_out});
		input_sag <= 1'b0;
		current_select_pin_a <= 1'b0;
		current_select_pin_b <= 1'b0;
		wr(cpp_pkg::LIMIT_ADDR, {14'h0, cpp_pkg::LIM_900});
		wr(cpp_pkg::CTRL_ADDR, 16'h0241);
		settle(8);
		check("override", 16'h3, {14'h0, input_current_ceiling});
		check("limit on", 16'h1, {15'h0, limit_active});
		input_overvoltage <= 1'b1;
		settle(8);
		check("limit ov", 16'h0, {15'h0, limit_active});
		input_overvoltage <= 1'b0;
		wr(cpp_pkg::CTRL_ADDR, 16'h0201);
		settle(8);
		check("limit dis", 16'h0, {15'h0, limit_active});
		$display("Test input limit done");

		wr(cpp_pkg::CTRL_ADDR, 16'h0041);
		input_detected <= 1'b0;
		load           <= 1'b1;
		wait_state(cpp_pkg::ST_OFF, 20);
		load           <= 1'b0;
		input_detected <= 1'b1;
		wait_state(cpp_pkg::ST_WEAK_CHARGE, 400);
		repeat (3)
		begin
			system_power_monitor_pin <= ~system_power_monitor_pin;
			repeat (6) @(posedge clk);
		end
		rd(cpp_pkg::STATUS_ADDR);
		check("power fail", 16'h1, {15'h0, |(rd_data[11:0] & 12'h0C0)});
		system_power_monitor_pin <= 1'b0;
		input_detected           <= 1'b0;
		gate_probe_high          <= 1'b0;
		wait_state(cpp_pkg::ST_OFF, 20);
		input_detected <= 1'b1;
		settle(40);
		rd(cpp_pkg::STATUS_ADDR);
		check("absent", 16'h0, {15'h0, rd_data[12]});
		wr(cpp_pkg::CTRL_ADDR, 16'h0045);
		rd(cpp_pkg::CTRL_ADDR);
		check("clear bit", 16'h0041, rd_data);
		wr(cpp_pkg::CTRL_ADDR, 16'h0143);
		rd(cpp_pkg::CTRL_ADDR);
		check("stack reset", {6'h00, cpp_pkg::CTRL_RESET}, rd_data);
		$display("Test weak exit and redetect done");
		wrap_up();
	end
endmodule

bind cpp_top cpp_checker chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .input_detected,
	.input_overvoltage, .bat_above_weak_threshold, .sense_below_recharge, .temp_warn,
	.temp_step_one, .temp_step_two, .temp_shutdown, .battery_switch_gate, .converter_en,
	.linear_safe_en, .linear_weak_en, .limit_active, .charge_current_out, .thermal_irq);
